// file: hw/clr_consts.svh
// Offsets, field positions and reset values of the converter link
// configuration registers.
// Assumes it is included by bare name wherever these constants are needed.
`ifndef CLR_CONSTS_SVH
`define CLR_CONSTS_SVH

`define CLR_ADDR_W 12
`define CLR_DATA_W 8

`define CLR_OFS_LANE_SWING 12'h03D
`define CLR_OFS_REF_SOFT 12'h057
`define CLR_OFS_SYNC_POL 12'h058
`define CLR_OFS_LOW_RATE1 12'h03F
`define CLR_OFS_LOW_RATE2 12'h042

`define CLR_AMP_MSB 2
`define CLR_AMP_LSB 0
`define CLR_SRC_SEL_BIT 3
`define CLR_SOFT_LEVEL_BIT 4
`define CLR_SYNC_INV_BIT 5
`define CLR_LOW_RATE1_BIT 2
`define CLR_LOW_RATE2_BIT 4

`define CLR_REG_RESET 8'h00
`define CLR_READ_UNMAPPED 8'h00

`endif

// file: hw/clr_pkg.sv
// Types shared by the converter link configuration register bank.
// Assumes clr_consts.svh is on the include path.
`include "clr_consts.svh"

package clr_pkg;

    // One register access, write or read, offered for a single cycle
    typedef struct packed {
        logic wrEn;
        logic rdEn;
        logic [`CLR_ADDR_W-1:0] addr;
        logic [`CLR_DATA_W-1:0] wrData;
    } clr_reg_req_t;

    // Every stored control bit of the bank
    typedef struct packed {
        logic [2:0] laneAmplitudeCode;
        logic referenceSourceSelect;
        logic referenceSoftLevel;
        logic syncRequestInvert;
        logic lowRateEnableFirst;
        logic lowRateEnableSecond;
    } clr_cfg_t;

endpackage : clr_pkg

// file: hw/clr_pin_filter.sv
// Three-stage pin synchroniser with agreement filter.
// Assumes the pin is asynchronous to mclk; output is a registered level.
module clr_pin_filter (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic pinIn,
    input wire logic resetLevel,
    output logic levelOut
);

    logic stage1_reg;
    logic stage2_reg;
    logic stage3_reg;
    logic started_reg;

    // First stage feeds only the second stage
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            stage1_reg <= 1'b0;
            stage2_reg <= 1'b0;
            stage3_reg <= 1'b0;
        end else begin
            stage1_reg <= pinIn;
            stage2_reg <= stage1_reg;
            stage3_reg <= stage2_reg;
        end
    end

    // Idle level is taken after release, never under reset
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            started_reg <= 1'b0;
            levelOut <= 1'b0;
        end else begin
            started_reg <= 1'b1;
            if (!started_reg) begin
                levelOut <= resetLevel;
            end else if (stage2_reg == stage3_reg) begin
                levelOut <= stage3_reg;
            end
        end
    end

endmodule : clr_pin_filter

// file: hw/clr_config_regs.sv
// Byte-wide configuration register bank of a dual-channel converter link:
// lane amplitude, software reference override, sync request polarity and
// the two low-rate enables.
// Assumes a serial front end delivers one decoded access per cycle on
// regReq, and that reference and sync pins are asynchronous to mclk.
//
// Overview of operation
// - Three-bit code sets amplitude for all lanes
// - Bit 3 selects pin or register reference
// - Bit 4 drives reference level when selected
// - Bit 5 inverts the sync request input
`include "clr_consts.svh"

module clr_config_regs
    import clr_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_b,
    input wire clr_reg_req_t regReq,
    output logic [`CLR_DATA_W-1:0] regRdData,
    output logic regRdValid,
    input wire logic referencePin,
    input wire logic syncReqPin_b,
    output clr_cfg_t cfgOut,
    output logic referenceOut,
    output logic syncReq_b
);

    ////////////////////////////////////////////////////////////////////////
    // Register storage

    clr_cfg_t cfg_reg;
    logic referenceFilt;
    logic syncReqFilt;

    function automatic logic isWrite(input clr_reg_req_t r,
                                     input logic [`CLR_ADDR_W-1:0] ofs);
        isWrite = r.wrEn && (r.addr == ofs);
    endfunction : isWrite

    // Only documented fields are stored; reserved bits are dropped
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            cfg_reg <= clr_cfg_t'(`CLR_REG_RESET);
        end else begin
            if (isWrite(regReq, `CLR_OFS_LANE_SWING)) begin
                cfg_reg.laneAmplitudeCode <=
                    regReq.wrData[`CLR_AMP_MSB:`CLR_AMP_LSB];
            end
            if (isWrite(regReq, `CLR_OFS_REF_SOFT)) begin
                cfg_reg.referenceSourceSelect <=
                    regReq.wrData[`CLR_SRC_SEL_BIT];
                cfg_reg.referenceSoftLevel <=
                    regReq.wrData[`CLR_SOFT_LEVEL_BIT];
            end
            if (isWrite(regReq, `CLR_OFS_SYNC_POL)) begin
                cfg_reg.syncRequestInvert <=
                    regReq.wrData[`CLR_SYNC_INV_BIT];
            end
            if (isWrite(regReq, `CLR_OFS_LOW_RATE1)) begin
                cfg_reg.lowRateEnableFirst <=
                    regReq.wrData[`CLR_LOW_RATE1_BIT];
            end
            if (isWrite(regReq, `CLR_OFS_LOW_RATE2)) begin
                cfg_reg.lowRateEnableSecond <=
                    regReq.wrData[`CLR_LOW_RATE2_BIT];
            end
        end
    end

    assign cfgOut = cfg_reg;

    ////////////////////////////////////////////////////////////////////////
    // Read back

    logic [`CLR_DATA_W-1:0] rdValue;

    // Reserved bits and unmapped offsets read as zero
    always_comb begin
        rdValue = `CLR_READ_UNMAPPED;
        case (regReq.addr)
            `CLR_OFS_LANE_SWING: begin
                rdValue[`CLR_AMP_MSB:`CLR_AMP_LSB] =
                    cfg_reg.laneAmplitudeCode;
            end
            `CLR_OFS_REF_SOFT: begin
                rdValue[`CLR_SRC_SEL_BIT] = cfg_reg.referenceSourceSelect;
                rdValue[`CLR_SOFT_LEVEL_BIT] = cfg_reg.referenceSoftLevel;
            end
            `CLR_OFS_SYNC_POL: begin
                rdValue[`CLR_SYNC_INV_BIT] = cfg_reg.syncRequestInvert;
            end
            `CLR_OFS_LOW_RATE1: begin
                rdValue[`CLR_LOW_RATE1_BIT] = cfg_reg.lowRateEnableFirst;
            end
            `CLR_OFS_LOW_RATE2: begin
                rdValue[`CLR_LOW_RATE2_BIT] = cfg_reg.lowRateEnableSecond;
            end
            default: begin
                rdValue = `CLR_READ_UNMAPPED;
            end
        endcase
    end

    // A read in the same cycle as a write returns the old contents
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            regRdData <= `CLR_READ_UNMAPPED;
            regRdValid <= 1'b0;
        end else begin
            regRdValid <= regReq.rdEn;
            if (regReq.rdEn) begin
                regRdData <= rdValue;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin conditioning

    clr_pin_filter u_referenceFilter (
        .mclk(mclk),
        .rst_b(rst_b),
        .pinIn(referencePin),
        .resetLevel(1'b0),
        .levelOut(referenceFilt)
    );

    // Sync pin enters inverted so its idle level matches the zeroed stages;
    // otherwise stale reset zeros would pose as a request after release
    clr_pin_filter u_syncFilter (
        .mclk(mclk),
        .rst_b(rst_b),
        .pinIn(~syncReqPin_b),
        .resetLevel(1'b0),
        .levelOut(syncReqFilt)
    );

    ////////////////////////////////////////////////////////////////////////
    // Internal reference and sync request

    // Host edges on the level bit only count once the source is selected
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            referenceOut <= 1'b0;
        end else if (cfg_reg.referenceSourceSelect) begin
            referenceOut <= cfg_reg.referenceSoftLevel;
        end else begin
            referenceOut <= referenceFilt;
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            syncReq_b <= 1'b1;
        end else begin
            syncReq_b <= ~syncReqFilt ^ cfg_reg.syncRequestInvert;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks

    property p_ampWrite;
        @(posedge mclk) disable iff (!rst_b)
        isWrite(regReq, `CLR_OFS_LANE_SWING) |=>
            cfgOut.laneAmplitudeCode ==
            $past(regReq.wrData[`CLR_AMP_MSB:`CLR_AMP_LSB]);
    endproperty
    a_ampWrite: assert property (p_ampWrite)
        else $error("lane amplitude code not stored");

    property p_ampHold;
        @(posedge mclk) disable iff (!rst_b)
        !isWrite(regReq, `CLR_OFS_LANE_SWING) |=>
            $stable(cfgOut.laneAmplitudeCode);
    endproperty
    a_ampHold: assert property (p_ampHold)
        else $error("lane amplitude code changed without write");

    sequence s_pinHighQuiet;
        (referencePin && !cfg_reg.referenceSourceSelect && !regReq.wrEn)[*7];
    endsequence

    property p_pinSource;
        @(posedge mclk) disable iff (!rst_b)
        s_pinHighQuiet |-> referenceOut;
    endproperty
    a_pinSource: assert property (p_pinSource)
        else $error("pin reference not passed through");

    sequence s_softSelected;
        (cfg_reg.referenceSourceSelect && !referencePin)[*2];
    endsequence

    property p_softLevel;
        @(posedge mclk) disable iff (!rst_b)
        s_softSelected |-> referenceOut == $past(cfg_reg.referenceSoftLevel);
    endproperty
    a_softLevel: assert property (p_softLevel)
        else $error("register reference level not driven");

    property p_softWriteToOut;
        @(posedge mclk) disable iff (!rst_b)
        isWrite(regReq, `CLR_OFS_REF_SOFT) &&
            regReq.wrData[`CLR_SRC_SEL_BIT] |-> ##2
            referenceOut == $past(regReq.wrData[`CLR_SOFT_LEVEL_BIT], 2);
    endproperty
    a_softWriteToOut: assert property (p_softWriteToOut)
        else $error("reference does not follow written level");

    property p_syncNormal;
        @(posedge mclk) disable iff (!rst_b)
        (syncReqPin_b && !cfg_reg.syncRequestInvert && !regReq.wrEn)[*7]
            |-> syncReq_b;
    endproperty
    a_syncNormal: assert property (p_syncNormal)
        else $error("sync request not taken with normal polarity");

    property p_syncInvert;
        @(posedge mclk) disable iff (!rst_b)
        (syncReqPin_b && cfg_reg.syncRequestInvert && !regReq.wrEn)[*7]
            |-> !syncReq_b;
    endproperty
    a_syncInvert: assert property (p_syncInvert)
        else $error("sync request not inverted");

    property p_refReadBack;
        @(posedge mclk) disable iff (!rst_b)
        regReq.rdEn && regReq.addr == `CLR_OFS_REF_SOFT |=>
            regRdValid &&
            regRdData[`CLR_SRC_SEL_BIT] ==
                $past(cfg_reg.referenceSourceSelect) &&
            regRdData[`CLR_SOFT_LEVEL_BIT] ==
                $past(cfg_reg.referenceSoftLevel) &&
            regRdData[2:0] == 3'h0;
    endproperty
    a_refReadBack: assert property (p_refReadBack)
        else $error("reference control read back wrong");

endmodule : clr_config_regs

// file: test/clr_host_model.sv
// Host model that issues single-cycle register accesses to the bank.
// Assumes the bank samples regReq on rising mclk and answers reads one
// cycle after the access.
module clr_host_model
    import clr_pkg::*;
(
    input wire logic mclk,
    output clr_reg_req_t regReq,
    input wire logic [7:0] regRdData,
    input wire logic regRdValid
);
    timeunit 1ns;
    timeprecision 100ps;

    initial regReq = '0;

    // Released address and data are inverted so stale values never match
    task automatic drive(input logic w, input logic [11:0] a,
                         input logic [7:0] d);
        @(negedge mclk);
        regReq <= '{w, !w, a, d};
        @(negedge mclk);
        regReq <= '{1'b0, 1'b0, ~a, ~d};
    endtask : drive

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        drive(1'b1, a, d);
    endtask : wr

    task automatic rd(input logic [11:0] a, output logic [7:0] v,
                      output logic ok);
        ok = 1'b0;
        v = 8'h00;
        drive(1'b0, a, 8'hA5);
        // Valid stands for one cycle only, so look before waiting
        for (int i = 0; i < 4 && ok !== 1'b1; i++) begin
            if (regRdValid === 1'b1) begin
                v = regRdData;
                ok = 1'b1;
            end else begin
                @(negedge mclk);
            end
        end
    endtask : rd
endmodule : clr_host_model

// file: test/tb.sv
// Self-checking bench for the converter link configuration bank.
// Assumes the host model drives the register port; pins come from here.
module tb;
    import clr_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;

    typedef struct packed {
        logic [11:0] addr;
        logic [7:0] data;
        clr_cfg_t cfgExp;
    } clr_row_t;

    // Legal writes in order: source select set before the level bit
    localparam clr_row_t ROWS [7] = '{
        '{12'h03D, 8'h04, 8'h80}, '{12'h057, 8'h08, 8'h90},
        '{12'h057, 8'h18, 8'h98}, '{12'h058, 8'h20, 8'h9C},
        '{12'h03F, 8'h04, 8'h9E}, '{12'h042, 8'h10, 8'h9F},
        '{12'h058, 8'h00, 8'h9B}};

    logic mclk;
    logic rst_b;
    clr_reg_req_t regReq;
    logic [7:0] regRdData;
    logic regRdValid;
    logic referencePin;
    logic syncReqPin_b;
    clr_cfg_t cfgOut;
    logic referenceOut;
    logic syncReq_b;
    int badCount = 0;
    int nChecks = 0;

    clr_config_regs i_clr_config_regs (
        .mclk(mclk), .rst_b(rst_b), .regReq(regReq),
        .regRdData(regRdData), .regRdValid(regRdValid),
        .referencePin(referencePin), .syncReqPin_b(syncReqPin_b),
        .cfgOut(cfgOut), .referenceOut(referenceOut),
        .syncReq_b(syncReq_b));

    clr_host_model i_clr_host_model (
        .mclk(mclk), .regReq(regReq), .regRdData(regRdData),
        .regRdValid(regRdValid));

    ////////////////////////////////////////////////////////////////////////
    task automatic conclude();
        $display("checks %0d errors %0d", nChecks, badCount);
        if (badCount == 0 && nChecks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : conclude

    task automatic chk(input string nm, input logic [7:0] e,
                       input logic [7:0] s);
        nChecks++;
        if (s !== e) begin
            badCount++;
            $display("ERROR %s exp %h got %h", nm, e, s);
        end
    endtask : chk

    task automatic rdChk(input logic [11:0] a, input logic [7:0] e);
        logic [7:0] v;
        logic ok;
        i_clr_host_model.rd(a, v, ok);
        if (ok !== 1'b1) begin
            badCount++;
            $display("ERROR readValid exp 1 got 0");
            conclude();
        end else begin
            chk("read", e, v);
        end
    endtask : rdChk

    // Longer than the four-edge pin filter latency
    task automatic settle();
        repeat (6) @(negedge mclk);
    endtask : settle

    ////////////////////////////////////////////////////////////////////////
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    initial begin
        repeat (20000) @(posedge mclk);
        badCount++;
        $display("ERROR watchdog exp done got hang");
        conclude();
    end

    initial begin
        rst_b = 1'b0;
        referencePin = 1'b0;
        syncReqPin_b = 1'b1;
        repeat (3) @(negedge mclk);
        rst_b = 1'b1;
        chk("cfgReset", 8'h00, cfgOut);
        chk("refReset", 8'h00, {7'h0, referenceOut});
        chk("syncReset", 8'h01, {7'h0, syncReq_b});
        @(negedge mclk);
        chk("syncIdle1", 8'h01, {7'h0, syncReq_b});
        chk("refIdle1", 8'h00, {7'h0, referenceOut});
        @(negedge mclk);
        chk("syncIdle2", 8'h01, {7'h0, syncReq_b});
        foreach (ROWS[i]) rdChk(ROWS[i].addr, 8'h00);
        foreach (ROWS[i]) begin
            i_clr_host_model.wr(ROWS[i].addr, ROWS[i].data);
            rdChk(ROWS[i].addr, ROWS[i].data);
            chk("cfg", ROWS[i].cfgExp, cfgOut);
        end
        for (int c = 0; c < 8; c++) begin
            i_clr_host_model.wr(12'h03D, 8'(c));
            chk("amp", 8'(c), {5'h0, cfgOut.laneAmplitudeCode});
        end
        // Pin high must be ignored while the register source is chosen
        referencePin = 1'b1;
        i_clr_host_model.wr(12'h057, 8'h08);
        settle();
        chk("refSoftLow", 8'h00, {7'h0, referenceOut});
        i_clr_host_model.wr(12'h057, 8'h00);
        settle();
        chk("refPinHigh", 8'h01, {7'h0, referenceOut});
        referencePin = 1'b0;
        settle();
        chk("refPinLow", 8'h00, {7'h0, referenceOut});
        i_clr_host_model.wr(12'h057, 8'h08);
        i_clr_host_model.wr(12'h057, 8'h18);
        settle();
        chk("refSoftHigh", 8'h01, {7'h0, referenceOut});
        syncReqPin_b = 1'b0;
        settle();
        chk("syncNormal", 8'h00, {7'h0, syncReq_b});
        i_clr_host_model.wr(12'h058, 8'h20);
        settle();
        chk("syncInvert", 8'h01, {7'h0, syncReq_b});
        i_clr_host_model.wr(12'h058, 8'h00);
        settle();
        chk("syncBack", 8'h00, {7'h0, syncReq_b});
        // Reserved bits and an unmapped offset must leave no trace
        i_clr_host_model.wr(12'h03D, 8'hFF);
        rdChk(12'h03D, 8'h07);
        i_clr_host_model.wr(12'h100, 8'hFF);
        rdChk(12'h100, 8'h00);
        chk("cfgKept", 8'hFB, cfgOut);
        rst_b = 1'b0;
        @(negedge mclk);
        chk("cfgReReset", 8'h00, cfgOut);
        rst_b = 1'b1;
        rdChk(12'h057, 8'h00);
        conclude();
    end
endmodule : tb
